// ===== src/aws_alu.sv
// ALU with working accumulator and status flag register
// Behaviour
// - 8-bit add, subtract, shift, logic operations
// - Accumulator plus file or immediate operand
// - Single operand from accumulator or file
// - Flags update only when instruction affects them or writes status
// - Subtract carries hold inverted borrow
// - Status at file 03h, writable destination
// - Affected flag bits ignore writes from flag-affecting results
// - Bit 5 selects data RAM bank
// - Bit 4 timeout, read-only, hardware set/clear
// - Bit 3 power-down, read-only, hardware set/clear
// - Bit 1 low nibble carry or not-borrow
// - Bit 0 carry out or not-borrow
`timescale 1ns/1ps
`default_nettype none
module aws_alu (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic i_exec,
	input wire aws_pkg::aws_op_t i_op,
	input wire aws_pkg::aws_src_t i_src,
	input wire aws_pkg::aws_aff_t i_affect,
	input wire logic [7:0] i_file_data,
	input wire logic [7:0] i_imm,
	input wire logic i_dest_file,
	input wire logic [6:0] i_dest_addr,
	input wire logic i_bit_op,
	input wire logic i_bit_set,
	input wire logic [2:0] i_bit_idx,
	input wire logic i_wdt_timeout,
	input wire logic i_wdt_clear,
	input wire logic i_sleep,
	input wire logic i_low_voltage_reset,
	output logic [7:0] o_result,
	output logic o_result_valid,
	output logic [7:0] o_acc,
	output logic [7:0] o_status,
	output logic o_ram_bank_select
);
	logic [7:0] acc;
	logic [7:0] status;
	logic [2:0] upper_bits;
	logic [2:0] flag_bits;
	logic timeout_flag;
	logic power_down_flag;
	logic [7:0] operand_a;
	logic [7:0] operand_b;
	logic [7:0] core_res;
	logic core_c;
	logic core_dc;
	logic [7:0] res;
	logic [7:0] next_flags;
	logic status_dest;
	logic [7:0] next_status_wr;

	function automatic logic [7:0] bit_mask(input logic [2:0] idx);
		bit_mask = 8'h01 << idx;
	endfunction : bit_mask

	function automatic logic affects(input aws_pkg::aws_aff_t a,
		input int b);
		case (a)
			aws_pkg::AWS_AFF_ALL: affects = 1'b1;
			aws_pkg::AWS_AFF_CZ: affects = (b != aws_pkg::BIT_DC);
			aws_pkg::AWS_AFF_Z: affects = (b == aws_pkg::BIT_Z);
			default: affects = 1'b0;
		endcase
	endfunction : affects

	// Operand select
	always_comb begin
		operand_a = acc;
		case (i_src)
			aws_pkg::AWS_SRC_IMM: operand_b = i_imm;
			aws_pkg::AWS_SRC_ACC: operand_b = acc;
			default: operand_b = i_file_data;
		endcase
	end

	aws_core u_core (
		.i_op(i_op),
		.i_a(operand_a),
		.i_b(operand_b),
		.i_carry(status[aws_pkg::BIT_C]),
		.o_res(core_res),
		.o_carry(core_c),
		.o_nib_carry(core_dc)
	);

	// Bit set/clear acts on the file operand
	always_comb begin
		if (i_bit_op) begin
			if (i_bit_set) begin
				res = i_file_data | bit_mask(i_bit_idx);
			end else begin
				res = i_file_data & ~bit_mask(i_bit_idx);
			end
		end else begin
			res = core_res;
		end
	end

	// Flags computed from the operation
	always_comb begin
		next_flags = 8'h00;
		next_flags[aws_pkg::BIT_C] = core_c;
		next_flags[aws_pkg::BIT_DC] = core_dc;
		next_flags[aws_pkg::BIT_Z] = (core_res == 8'h00);
	end

	assign status_dest = i_dest_file && (i_dest_addr == aws_pkg::STATUS_ADDR);

	// Status value from a file write, then flags override
	always_comb begin
		next_status_wr = status;
		if (i_exec && status_dest) begin
			next_status_wr = (status & ~aws_pkg::WR_MASK)
				| (res & aws_pkg::WR_MASK);
		end
		for (int b = 0; b < 3; b++) begin
			if (i_exec && !i_bit_op && affects(i_affect, b)) begin
				next_status_wr[b] = next_flags[b];
			end
		end
	end

	// Arithmetic, bank and spare bits
	always_ff @(posedge I_CLK) begin
		if (I_RST || i_low_voltage_reset) begin
			upper_bits <= aws_pkg::STATUS_RESET[7:5];
			flag_bits <= aws_pkg::STATUS_RESET[2:0];
		end else begin
			upper_bits <= next_status_wr[7:5];
			flag_bits <= next_status_wr[2:0];
		end
	end

	// Timeout flag, set wins over clear
	always_ff @(posedge I_CLK) begin
		if (I_RST || i_low_voltage_reset) begin
			timeout_flag <= aws_pkg::STATUS_RESET[aws_pkg::BIT_TO];
		end else if (i_wdt_timeout) begin
			timeout_flag <= 1'b1;
		end else if (i_wdt_clear || i_sleep) begin
			timeout_flag <= 1'b0;
		end
	end

	// Power-down flag, clear wins over sleep
	always_ff @(posedge I_CLK) begin
		if (I_RST || i_low_voltage_reset || i_wdt_clear) begin
			power_down_flag <= aws_pkg::STATUS_RESET[aws_pkg::BIT_PD];
		end else if (i_sleep) begin
			power_down_flag <= 1'b1;
		end
	end

	// Status word gathered from its separately owned parts
	always_comb begin
		status = aws_pkg::STATUS_RESET;
		status[7:5] = upper_bits;
		status[aws_pkg::BIT_TO] = timeout_flag;
		status[aws_pkg::BIT_PD] = power_down_flag;
		status[2:0] = flag_bits;
	end

	// Accumulator
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			acc <= 8'h00;
		end else if (i_exec && !i_dest_file) begin
			acc <= res;
		end
	end

	// Result to file datapath
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			o_result <= 8'h00;
			o_result_valid <= 1'b0;
		end else begin
			o_result <= res;
			o_result_valid <= i_exec && i_dest_file && !status_dest;
		end
	end

	assign o_acc = acc;
	assign o_status = status;
	assign o_ram_bank_select = status[aws_pkg::BIT_BANK];
endmodule : aws_alu
`default_nettype wire

// ===== common/aws_pkg.sv
// Package of constants and types for the ALU with status flags
package aws_pkg;
	localparam int DATA_W = 8;
	localparam logic [6:0] STATUS_ADDR = 7'h03;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int BIT_C = 0;
	localparam int BIT_DC = 1;
	localparam int BIT_Z = 2;
	localparam int BIT_PD = 3;
	localparam int BIT_TO = 4;
	localparam int BIT_BANK = 5;
	localparam int BIT_SP1 = 6;
	localparam int BIT_SP0 = 7;
	localparam logic [7:0] FLAG_MASK = 8'h07;
	localparam logic [7:0] RO_MASK = 8'h18;
	localparam logic [7:0] WR_MASK = 8'he7;
	typedef enum logic [3:0] {
		AWS_OP_PASS = 4'h0,
		AWS_OP_ADD = 4'h1,
		AWS_OP_SUB = 4'h2,
		AWS_OP_AND = 4'h3,
		AWS_OP_OR = 4'h4,
		AWS_OP_XOR = 4'h5,
		AWS_OP_COM = 4'h6,
		AWS_OP_INC = 4'h7,
		AWS_OP_DEC = 4'h8,
		AWS_OP_RL = 4'h9,
		AWS_OP_RR = 4'ha,
		AWS_OP_SWAP = 4'hb,
		AWS_OP_CLR = 4'hc
	} aws_op_t;
	typedef enum logic [1:0] {
		AWS_SRC_FILE = 2'h0,
		AWS_SRC_IMM = 2'h1,
		AWS_SRC_ACC = 2'h2
	} aws_src_t;
	typedef enum logic [1:0] {
		AWS_AFF_NONE = 2'h0,
		AWS_AFF_Z = 2'h1,
		AWS_AFF_CZ = 2'h2,
		AWS_AFF_ALL = 2'h3
	} aws_aff_t;
endpackage : aws_pkg

// ===== src/aws_core.sv
// Combinational 8-bit arithmetic and logic core
`timescale 1ns/1ps
`default_nettype none
module aws_core (
	input wire aws_pkg::aws_op_t i_op,
	input wire logic [7:0] i_a,
	input wire logic [7:0] i_b,
	input wire logic i_carry,
	output logic [7:0] o_res,
	output logic o_carry,
	output logic o_nib_carry
);
	logic [8:0] sum;
	logic [4:0] nib;
	always_comb begin
		sum = 9'h000;
		nib = 5'h00;
		o_res = i_b;
		o_carry = i_carry;
		o_nib_carry = 1'b0;
		case (i_op)
			aws_pkg::AWS_OP_PASS: o_res = i_b;
			aws_pkg::AWS_OP_ADD: begin
				sum = {1'b0, i_a} + {1'b0, i_b};
				nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
				o_res = sum[7:0];
				o_carry = sum[8];
				o_nib_carry = nib[4];
			end
			aws_pkg::AWS_OP_SUB: begin // b minus a, borrow inverted
				sum = {1'b0, i_b} + {1'b0, ~i_a} + 9'h001;
				nib = {1'b0, i_b[3:0]} + {1'b0, ~i_a[3:0]} + 5'h01;
				o_res = sum[7:0];
				o_carry = sum[8];
				o_nib_carry = nib[4];
			end
			aws_pkg::AWS_OP_AND: o_res = i_a & i_b;
			aws_pkg::AWS_OP_OR: o_res = i_a | i_b;
			aws_pkg::AWS_OP_XOR: o_res = i_a ^ i_b;
			aws_pkg::AWS_OP_COM: o_res = ~i_b;
			aws_pkg::AWS_OP_INC: o_res = i_b + 8'h01;
			aws_pkg::AWS_OP_DEC: o_res = i_b - 8'h01;
			aws_pkg::AWS_OP_RL: begin
				o_res = {i_b[6:0], i_carry};
				o_carry = i_b[7];
			end
			aws_pkg::AWS_OP_RR: begin
				o_res = {i_carry, i_b[7:1]};
				o_carry = i_b[0];
			end
			aws_pkg::AWS_OP_SWAP: o_res = {i_b[3:0], i_b[7:4]};
			aws_pkg::AWS_OP_CLR: o_res = 8'h00;
			default: o_res = i_b;
		endcase
	end
endmodule : aws_core
`default_nettype wire

// ===== bench/aws_file_model.sv
// File register model feeding the ALU operand
`timescale 1ns/1ps
`default_nettype none
module aws_file_model (
	input wire logic i_clk,
	input wire logic i_we,
	input wire logic [7:0] i_wdata,
	input wire logic [6:0] i_addr,
	input wire logic [7:0] i_status,
	output logic [7:0] o_rdata
);
	logic [7:0] held = 8'h00;
	always @(posedge i_clk) begin
		if (i_we) held <= i_wdata;
	end
	// Status reads return the flag register; a pending write is forwarded
	always_comb begin
		if (i_addr == aws_pkg::STATUS_ADDR) o_rdata = i_status;
		else if (i_we) o_rdata = i_wdata;
		else o_rdata = held;
	end
endmodule : aws_file_model
`default_nettype wire

// ===== bench/aws_alu_asserts.sv
// Assertions on the ALU status flags
`timescale 1ns/1ps
`default_nettype none
module aws_asserts (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic i_exec,
	input wire aws_pkg::aws_aff_t i_affect,
	input wire logic i_dest_file,
	input wire logic [6:0] i_dest_addr,
	input wire logic i_bit_op,
	input wire logic i_wdt_timeout,
	input wire logic i_wdt_clear,
	input wire logic i_sleep,
	input wire logic i_low_voltage_reset,
	input wire logic o_result_valid,
	input wire logic [7:0] o_acc,
	input wire logic [7:0] o_status,
	input wire logic o_ram_bank_select
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);
	logic sw, hw;
	assign sw = i_exec && i_dest_file && i_dest_addr == 7'h03;
	assign hw = i_wdt_timeout | i_wdt_clear | i_sleep | i_low_voltage_reset;
	sequence acc_op;
		i_exec && !i_dest_file && !i_bit_op && !hw
		&& i_affect != aws_pkg::AWS_AFF_NONE;
	endsequence
	chk_bank_out: assert property (
		o_ram_bank_select == o_status[5]) else $error("bank bit");
	chk_to_set: assert property (
		i_wdt_timeout && !i_low_voltage_reset |=> o_status[4]) else $error("to");
	chk_pd_set: assert property (
		i_sleep && !i_wdt_clear && !i_low_voltage_reset
		|=> o_status[3]) else $error("pd");
	chk_ro_bits: assert property (
		sw && !hw |=> $stable(o_status[4:3])) else $error("ro bits");
	chk_zero_flag: assert property (
		acc_op |=> o_status[2] == (o_acc == 8'h00)) else $error("zero");
	chk_flag_hold: assert property (
		i_exec && i_affect == aws_pkg::AWS_AFF_NONE && !i_bit_op && !sw && !hw
		|=> $stable(o_status[2:0])) else $error("flags moved");
	chk_idle_hold: assert property (
		!i_exec && !hw |=> $stable(o_acc) && $stable(o_status)) else $error("idle");
	chk_file_valid: assert property (
		i_exec && i_dest_file |=> o_result_valid != $past(sw)) else $error("wr");
endmodule : aws_asserts
bind aws_alu aws_asserts i_chk (
	.I_CLK(I_CLK),
	.I_RST(I_RST),
	.i_exec(i_exec),
	.i_affect(i_affect),
	.i_dest_file(i_dest_file),
	.i_dest_addr(i_dest_addr),
	.i_bit_op(i_bit_op),
	.i_wdt_timeout(i_wdt_timeout),
	.i_wdt_clear(i_wdt_clear),
	.i_sleep(i_sleep),
	.i_low_voltage_reset(i_low_voltage_reset),
	.o_result_valid(o_result_valid),
	.o_acc(o_acc),
	.o_status(o_status),
	.o_ram_bank_select(o_ram_bank_select)
);
`default_nettype wire

// ===== bench/tb_top.sv
// Testbench for the ALU with status flags
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic I_CLK=0, I_RST=1, i_exec=0, i_dest_file=0, i_bit_op=0, i_bit_set=0;
	logic i_wdt_timeout=0, i_wdt_clear=0, i_sleep=0, i_low_voltage_reset=0;
	aws_pkg::aws_op_t i_op=aws_pkg::AWS_OP_PASS;
	aws_pkg::aws_src_t i_src=aws_pkg::AWS_SRC_IMM;
	aws_pkg::aws_aff_t i_affect=aws_pkg::AWS_AFF_NONE;
	logic [7:0] i_file_data, i_imm=0, o_result, o_acc, o_status;
	logic [6:0] i_dest_addr=0;
	logic [2:0] i_bit_idx=3'h5;
	logic o_result_valid, o_ram_bank_select;
	int fails=0, comparisons=0;
	always #5 I_CLK = ~I_CLK;
	aws_alu i_dut (
		.I_CLK(I_CLK),
		.I_RST(I_RST),
		.i_exec(i_exec),
		.i_op(i_op),
		.i_src(i_src),
		.i_affect(i_affect),
		.i_file_data(i_file_data),
		.i_imm(i_imm),
		.i_dest_file(i_dest_file),
		.i_dest_addr(i_dest_addr),
		.i_bit_op(i_bit_op),
		.i_bit_set(i_bit_set),
		.i_bit_idx(i_bit_idx),
		.i_wdt_timeout(i_wdt_timeout),
		.i_wdt_clear(i_wdt_clear),
		.i_sleep(i_sleep),
		.i_low_voltage_reset(i_low_voltage_reset),
		.o_result(o_result),
		.o_result_valid(o_result_valid),
		.o_acc(o_acc),
		.o_status(o_status),
		.o_ram_bank_select(o_ram_bank_select)
	);
	aws_file_model i_fm (
		.i_clk(I_CLK),
		.i_we(o_result_valid),
		.i_wdata(o_result),
		.i_addr(i_dest_addr),
		.i_status(o_status),
		.o_rdata(i_file_data)
	);
	task chk(input logic [7:0] g, e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: %h not %h", $time, g, e);
		end
	endtask : chk
	task ex(input logic [3:0] o, input logic [1:0] s, f,
		input logic [7:0] b, input logic [6:0] a);
		i_op = aws_pkg::aws_op_t'(o);
		i_src = aws_pkg::aws_src_t'(s);
		i_affect = aws_pkg::aws_aff_t'(f);
		i_imm = b;
		i_dest_addr = a;
		i_dest_file = a != 7'h0;
		i_exec = 1;
		@(posedge I_CLK);
		#1;
	endtask : ex
	task hw(input logic [3:0] m, input logic [7:0] e);
		{i_wdt_timeout, i_wdt_clear, i_sleep, i_low_voltage_reset} = m;
		@(posedge I_CLK);
		#1 {i_wdt_timeout, i_wdt_clear, i_sleep, i_low_voltage_reset} = 4'h0;
		chk(o_status, e);
		@(posedge I_CLK);
		#1;
	endtask : hw
	task stop_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		#100000;
		fails++;
		stop_test();
	end
	initial begin
		repeat (20) @(posedge I_CLK);
		#1 I_RST = 0;
		chk(o_status, 8'h00);
		ex(4'h0, 2'h1, 2'h0, 8'hff, 7'h0);
		ex(4'h1, 2'h1, 2'h3, 8'h01, 7'h0);
		chk(o_status, 8'h07);
		ex(4'h2, 2'h1, 2'h3, 8'h01, 7'h0);
		chk(o_status, 8'h03);
		ex(4'h2, 2'h1, 2'h3, 8'h00, 7'h0);
		chk(o_acc, 8'hff);
		chk(o_status, 8'h00);
		ex(4'h5, 2'h1, 2'h1, 8'hff, 7'h0);
		chk(o_status, 8'h04);
		ex(4'h0, 2'h1, 2'h0, 8'h81, 7'h0);
		ex(4'h9, 2'h2, 2'h2, 8'h00, 7'h0);
		chk(o_acc, 8'h02);
		chk(o_status, 8'h01);
		$display("test 1 done");
		ex(4'h0, 2'h1, 2'h0, 8'hff, 7'h0);
		ex(4'h0, 2'h2, 2'h0, 8'h00, 7'h03);
		chk(o_status, 8'he7);
		chk({o_result_valid, 6'h0, o_ram_bank_select}, 8'h01);
		ex(4'h1, 2'h1, 2'h3, 8'h00, 7'h03);
		chk(o_status, 8'he0);
		i_bit_op = 1;
		ex(4'h0, 2'h2, 2'h0, 8'h00, 7'h03);
		chk(o_status, 8'hc0);
		i_bit_op = 0;
		i_exec = 0;
		hw(4'h8, 8'hd0);
		hw(4'h2, 8'hc8);
		hw(4'h4, 8'hc0);
		hw(4'h1, 8'h00);
		$display("test 2 done");
		ex(4'h0, 2'h1, 2'h0, 8'h5a, 7'h0);
		ex(4'h1, 2'h0, 2'h3, 8'h00, 7'h20);
		chk(o_result, 8'h5a);
		chk({7'h0, o_result_valid}, 8'h01);
		ex(4'h1, 2'h0, 2'h0, 8'h00, 7'h0);
		chk(o_acc, 8'hb4);
		$display("test 3 done");
		ex(4'h3, 2'h1, 2'h1, 8'h0f, 7'h0);
		chk(o_acc, 8'h04);
		ex(4'h4, 2'h1, 2'h1, 8'h30, 7'h0);
		chk(o_acc, 8'h34);
		ex(4'h6, 2'h2, 2'h1, 8'h00, 7'h0);
		chk(o_acc, 8'hcb);
		ex(4'ha, 2'h2, 2'h2, 8'h00, 7'h0);
		chk(o_acc, 8'h65);
		chk(o_status, 8'h01);
		ex(4'h7, 2'h2, 2'h1, 8'h00, 7'h0);
		chk(o_acc, 8'h66);
		ex(4'h8, 2'h2, 2'h1, 8'h00, 7'h0);
		chk(o_acc, 8'h65);
		ex(4'hb, 2'h2, 2'h0, 8'h00, 7'h0);
		chk(o_acc, 8'h56);
		ex(4'hc, 2'h2, 2'h1, 8'h00, 7'h0);
		chk(o_acc, 8'h00);
		chk(o_status, 8'h05);
		i_bit_op = 1;
		i_bit_set = 1;
		i_bit_idx = 3'h7;
		ex(4'h0, 2'h2, 2'h0, 8'h00, 7'h03);
		chk(o_status, 8'h85);
		i_bit_op = 0;
		i_exec = 0;
		$display("test 4 done");
		I_RST = 1;
		@(posedge I_CLK);
		#1 I_RST = 0;
		chk(o_acc, 8'h00);
		chk(o_status, 8'h00);
		$display("test 5 done");
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
